//--- dpg_consts.svh
// Constants for the partial write guard ECC block
`ifndef DPG_CONSTS_SVH
`define DPG_CONSTS_SVH
`define DPG_DATA_W 64
`define DPG_ECC_W 8
`define DPG_BE_W 8
`define DPG_ADDR_W 32
`define DPG_NUM_RANGES 2
`define DPG_SYN_W 7
`define DPG_WORD_LSB 3
`endif

//--- dpg_pkg.sv
// Types shared by the partial write guard ECC block
`include "dpg_consts.svh"
package dpg_pkg;
    typedef struct packed {
        logic [`DPG_ADDR_W-1:0] base;
        logic [`DPG_ADDR_W-1:0] limit;
    } dpg_range_t;

    typedef struct packed {
        logic [`DPG_ADDR_W-1:0] addr;
        logic [`DPG_DATA_W-1:0] data;
        logic [`DPG_BE_W-1:0] be;
        logic write;
    } dpg_req_t;

    typedef struct packed {
        logic [`DPG_DATA_W-1:0] data;
        logic [`DPG_ECC_W-1:0] ecc;
    } dpg_word_t;

    typedef enum logic [2:0] {
        DPG_IDLE,
        DPG_MEM_RD,
        DPG_MEM_WAIT,
        DPG_MERGE_WR,
        DPG_DONE
    } dpg_state_t;
endpackage

//--- dpg_ecc_codec.sv
// Hamming SECDED encoder and decoder for one 64-bit word
`timescale 1ns/1ns
module dpg_ecc_codec (
    input wire logic [63:0] enc_data,
    output logic [7:0] enc_ecc,
    input wire logic [63:0] dec_data,
    input wire logic [7:0] dec_ecc,
    output logic [63:0] dec_fixed,
    output logic dec_single,
    output logic dec_double
);
    // Position of data bit i in a 72-bit Hamming code, skipping powers of two
    function automatic logic [6:0] dpg_pos(input int i);
        int p;
        int n;
        p = 1;
        n = 0;
        for (int k = 1; k < 72; k++) begin
            if ((k & (k - 1)) != 0) begin
                if (n == i) begin
                    p = k;
                end
                n = n + 1;
            end
        end
        return 7'(p);
    endfunction

    // Seven check bits plus one overall parity bit
    function automatic logic [7:0] dpg_code(input logic [63:0] d);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 0; i < 64; i++) begin
            if (d[i]) begin
                c = c ^ dpg_pos(i);
            end
        end
        return {(^d) ^ (^c), c};
    endfunction

    logic [7:0] recomputed;
    logic [6:0] syn;
    logic par_err;

    // Encode and syndrome
    always_comb begin
        enc_ecc = dpg_code(enc_data);
        recomputed = dpg_code(dec_data);
        syn = recomputed[6:0] ^ dec_ecc[6:0];
        par_err = (^dec_data) ^ (^dec_ecc);
    end

    // Correct one bit; even parity with nonzero syndrome means two bits bad
    always_comb begin
        dec_fixed = dec_data;
        for (int i = 0; i < 64; i++) begin
            if (par_err && (syn == dpg_pos(i))) begin
                dec_fixed[i] = ~dec_data[i];
            end
        end
        dec_single = par_err;
        dec_double = !par_err && (syn != 7'h00);
    end
endmodule

//--- dpg_guard.sv
// ECC guard with partial write merge between system bus and DDR3 port
//
// Function
// - Only addresses inside a configured protected range get check codes written and checked.
// - Each 64-bit protected word is stored with an 8-bit check code alongside it.
// - Protection is live only while both the protection enable and the byte lane enable are set.
// - Setting the partial write merge enable turns on read-modify-write handling.
// - With merge enabled, protected accesses of any alignment and size keep correct codes.
// - With merge disabled, unaligned or partial protected accesses are refused again.
`timescale 1ns/1ns
`include "dpg_consts.svh"
module dpg_guard (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ecc_enable,
    input wire logic byte_lane_enable_bit,
    input wire logic partial_write_merge_enable,
    input wire dpg_pkg::dpg_range_t [`DPG_NUM_RANGES-1:0] prot_ranges,
    input wire logic req_valid,
    input wire dpg_pkg::dpg_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [`DPG_DATA_W-1:0] rsp_data,
    output logic rsp_error,
    output logic err_corrected,
    output logic err_uncorrectable,
    output logic mem_valid,
    output logic mem_write,
    output logic [`DPG_ADDR_W-1:0] mem_addr,
    output dpg_pkg::dpg_word_t mem_wdata,
    output logic [`DPG_BE_W+0:0] mem_wmask,
    input wire logic mem_ready,
    input wire logic mem_rvalid,
    input wire dpg_pkg::dpg_word_t mem_rdata
);
    // Range decode shared by request classification
    function automatic logic dpg_in_range(input logic [`DPG_ADDR_W-1:0] a,
                                          input dpg_pkg::dpg_range_t [`DPG_NUM_RANGES-1:0] r);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `DPG_NUM_RANGES; i++) begin
            if (a >= r[i].base && a <= r[i].limit) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    dpg_pkg::dpg_state_t state_q, state_d;
    dpg_pkg::dpg_req_t cur_q, cur_d;
    logic prot_q, prot_d;
    logic req_ready_q, req_ready_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [`DPG_DATA_W-1:0] rsp_data_q, rsp_data_d;
    logic rsp_error_q, rsp_error_d;
    logic err_corr_q, err_corr_d;
    logic err_unc_q, err_unc_d;
    logic mem_valid_q, mem_valid_d;
    logic mem_write_q, mem_write_d;
    logic [`DPG_ADDR_W-1:0] mem_addr_q, mem_addr_d;
    dpg_pkg::dpg_word_t mem_wdata_q, mem_wdata_d;
    logic [`DPG_BE_W:0] mem_wmask_q, mem_wmask_d;
    logic [`DPG_DATA_W-1:0] merged;
    logic [`DPG_DATA_W-1:0] enc_src;
    logic [`DPG_ECC_W-1:0] enc_ecc;
    logic [`DPG_DATA_W-1:0] dec_fixed;
    logic dec_single, dec_double;
    logic prot_on;
    logic whole_word;
    logic hit;

    // Encoder sees either the merged word or the fresh request data
    dpg_ecc_codec u_codec (
        .enc_data(enc_src),
        .enc_ecc(enc_ecc),
        .dec_data(mem_rdata.data),
        .dec_ecc(mem_rdata.ecc),
        .dec_fixed(dec_fixed),
        .dec_single(dec_single),
        .dec_double(dec_double)
    );

    // Byte merge of write data over the word read back from memory
    generate
        for (genvar b = 0; b < `DPG_BE_W; b++) begin : g_merge
            assign merged[b*8 +: 8] = cur_q.be[b] ? cur_q.data[b*8 +: 8] : dec_fixed[b*8 +: 8];
        end
    endgenerate

    // Request classification
    always_comb begin
        prot_on = ecc_enable && byte_lane_enable_bit;
        hit = dpg_in_range(req.addr, prot_ranges) && prot_on;
        whole_word = (req.addr[`DPG_WORD_LSB-1:0] == 3'h0) && (&req.be);
        enc_src = (state_q == dpg_pkg::DPG_MEM_WAIT) ? merged : req.data;
    end

    // Transfer sequencer; one request at a time, masters keep bursts inside one region
    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        prot_d = prot_q;
        req_ready_d = 1'b0;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        rsp_error_d = 1'b0;
        err_corr_d = 1'b0;
        err_unc_d = 1'b0;
        mem_valid_d = mem_valid_q && !mem_ready;
        mem_write_d = mem_write_q;
        mem_addr_d = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        mem_wmask_d = mem_wmask_q;
        case (state_q)
            dpg_pkg::DPG_IDLE: begin
                req_ready_d = 1'b1;
                if (req_valid && req_ready_q) begin
                    req_ready_d = 1'b0;
                    cur_d = req;
                    prot_d = hit;
                    if (hit && !whole_word && !partial_write_merge_enable) begin
                        rsp_valid_d = 1'b1;
                        rsp_error_d = 1'b1;
                        state_d = dpg_pkg::DPG_DONE;
                    end else if (hit && req.write && !whole_word) begin
                        mem_valid_d = 1'b1;
                        mem_write_d = 1'b0;
                        mem_addr_d = {req.addr[`DPG_ADDR_W-1:`DPG_WORD_LSB], 3'h0};
                        state_d = dpg_pkg::DPG_MEM_RD;
                    end else begin
                        mem_valid_d = 1'b1;
                        mem_write_d = req.write;
                        mem_addr_d = {req.addr[`DPG_ADDR_W-1:`DPG_WORD_LSB], 3'h0};
                        mem_wdata_d.data = req.data;
                        mem_wdata_d.ecc = hit ? enc_ecc : 8'h00;
                        mem_wmask_d = {hit, req.be}; // Top bit lane carries the check byte
                        state_d = req.write ? dpg_pkg::DPG_MERGE_WR : dpg_pkg::DPG_MEM_WAIT;
                    end
                end
            end
            dpg_pkg::DPG_MEM_RD: begin
                if (mem_ready) begin
                    state_d = dpg_pkg::DPG_MEM_WAIT;
                end
            end
            dpg_pkg::DPG_MEM_WAIT: begin
                if (mem_rvalid) begin
                    err_corr_d = prot_q && dec_single;
                    err_unc_d = prot_q && dec_double;
                    if (cur_q.write) begin
                        mem_valid_d = 1'b1;
                        mem_write_d = 1'b1;
                        mem_wdata_d.data = merged;
                        mem_wdata_d.ecc = enc_ecc;
                        mem_wmask_d = {1'b1, 8'hff};
                        state_d = dpg_pkg::DPG_MERGE_WR;
                    end else begin
                        rsp_valid_d = 1'b1;
                        rsp_data_d = prot_q ? dec_fixed : mem_rdata.data;
                        rsp_error_d = prot_q && dec_double;
                        state_d = dpg_pkg::DPG_DONE;
                    end
                end
            end
            dpg_pkg::DPG_MERGE_WR: begin
                if (mem_valid_q && mem_ready) begin
                    rsp_valid_d = 1'b1;
                    state_d = dpg_pkg::DPG_DONE;
                end
            end
            dpg_pkg::DPG_DONE: begin
                req_ready_d = 1'b1;
                state_d = dpg_pkg::DPG_IDLE;
            end
            default: begin
                state_d = dpg_pkg::DPG_IDLE;
            end
        endcase
    end

    // Register everything; synchronous active-low reset
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q <= dpg_pkg::DPG_IDLE;
            cur_q <= '0;
            prot_q <= 1'b0;
            req_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 64'h0;
            rsp_error_q <= 1'b0;
            err_corr_q <= 1'b0;
            err_unc_q <= 1'b0;
            mem_valid_q <= 1'b0;
            mem_write_q <= 1'b0;
            mem_addr_q <= 32'h0;
            mem_wdata_q <= '0;
            mem_wmask_q <= 9'h000;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            prot_q <= prot_d;
            req_ready_q <= req_ready_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            rsp_error_q <= rsp_error_d;
            err_corr_q <= err_corr_d;
            err_unc_q <= err_unc_d;
            mem_valid_q <= mem_valid_d;
            mem_write_q <= mem_write_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
            mem_wmask_q <= mem_wmask_d;
        end
    end

    assign req_ready = req_ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign rsp_error = rsp_error_q;
    assign err_corrected = err_corr_q;
    assign err_uncorrectable = err_unc_q;
    assign mem_valid = mem_valid_q;
    assign mem_write = mem_write_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    assign mem_wmask = mem_wmask_q;
endmodule

//--- dpg_guard_asserts.sv
// Port checker for the partial write guard
`timescale 1ns/1ns
`include "dpg_consts.svh"
module dpg_guard_asserts (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ecc_enable,
    input wire logic byte_lane_enable_bit,
    input wire logic partial_write_merge_enable,
    input wire dpg_pkg::dpg_range_t [`DPG_NUM_RANGES-1:0] prot_ranges,
    input wire logic req_valid,
    input wire dpg_pkg::dpg_req_t req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    input wire logic err_corrected,
    input wire logic err_uncorrectable,
    input wire logic mem_valid,
    input wire logic mem_write,
    input wire logic [`DPG_ADDR_W-1:0] mem_addr,
    input wire logic [`DPG_BE_W+0:0] mem_wmask,
    input wire logic mem_ready
);
    logic on, rhit, mhit, odd, refuse, merge;
    // Range hits for the request and for the memory address
    always_comb begin
        rhit = 1'b0;
        mhit = 1'b0;
        for (int i = 0; i < `DPG_NUM_RANGES; i++) begin
            rhit = rhit | (req.addr >= prot_ranges[i].base && req.addr <= prot_ranges[i].limit);
            mhit = mhit | (mem_addr >= prot_ranges[i].base && mem_addr <= prot_ranges[i].limit);
        end
    end
    // A misfit is unaligned or partial; guarding needs both enables
    assign on = ecc_enable && byte_lane_enable_bit;
    assign odd = req.addr[2:0] != 3'h0 || req.be != 8'hff;
    assign refuse = req_valid && req_ready && on && rhit && odd && !partial_write_merge_enable;
    assign merge = req_valid && req_ready && on && rhit && odd && partial_write_merge_enable && req.write;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    AST_REFUSE_FLAG: assert property (refuse |=> rsp_valid && rsp_error)
        else $error("misfit not refused");
    AST_REFUSE_NOMEM: assert property (refuse |=> !mem_valid [*2])
        else $error("refused access reached memory");
    AST_RMW_READ: assert property (merge |=> mem_valid && !mem_write)
        else $error("merge did not read first");
    AST_RMW_BACK: assert property (merge |-> ##[2:60] (mem_valid && mem_write && mem_wmask[8]))
        else $error("merge never wrote back");
    AST_PROT_CODE: assert property (mem_valid && mem_write && on && mhit |-> mem_wmask[8])
        else $error("guarded write lacks check byte");
    AST_OPEN_NOCODE: assert property (mem_valid && mem_write && !(on && mhit) |-> !mem_wmask[8])
        else $error("open write touched check byte");
    AST_OFF_QUIET: assert property (!on |-> !err_corrected && !err_uncorrectable)
        else $error("error flag while guard off");
    AST_PASS_OPEN: assert property (req_valid && req_ready && !(on && rhit) |=> mem_valid)
        else $error("open access not passed");
    AST_MEM_HOLD: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr))
        else $error("memory request dropped");
    cover property (refuse);
    cover property (merge);
    cover property (err_corrected);
    cover property (err_uncorrectable);
endmodule
bind dpg_guard dpg_guard_asserts u_dpg_guard_asserts (.ref_clk, .rstn, .ecc_enable, .byte_lane_enable_bit,
    .partial_write_merge_enable, .prot_ranges, .req_valid, .req, .req_ready, .rsp_valid, .rsp_error,
    .err_corrected, .err_uncorrectable, .mem_valid, .mem_write, .mem_addr, .mem_wmask, .mem_ready);

//--- dpg_mem_model.sv
// Behavioural DDR3 word store behind the guard's memory port
`timescale 1ns/1ns
module dpg_mem_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic [1:0] flip,
    input wire logic mem_valid,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire dpg_pkg::dpg_word_t mem_wdata,
    input wire logic [8:0] mem_wmask,
    output logic mem_ready,
    output logic mem_rvalid,
    output dpg_pkg::dpg_word_t mem_rdata
);
    dpg_pkg::dpg_word_t mem [logic [28:0]];
    dpg_pkg::dpg_word_t w;
    logic [1:0] cnt;
    logic pend;
    // Slow mode stalls each handshake; idle read bus toggles so stale data never passes
    always_ff @(posedge ref_clk) begin
        mem_ready <= 1'b0;
        mem_rvalid <= pend;
        pend <= 1'b0;
        mem_rdata <= pend ? w ^ {54'h0, flip[1], 3'h0, |flip, 13'h0} : ~mem_rdata;
        if (!rstn) begin
            cnt <= 2'h0;
            pend <= 1'b0;
            mem_rdata <= '0;
        end else if (mem_valid && !mem_ready) begin
            cnt <= cnt + 2'h1;
            if (cnt == {slow, slow}) begin
                cnt <= 2'h0;
                mem_ready <= 1'b1;
                pend <= !mem_write;
                w = mem.exists(mem_addr[31:3]) ? mem[mem_addr[31:3]] : '0;
                // Lane 8 is the check byte, stored beside its word
                for (int i = 0; i < 9; i++) begin
                    if (mem_write && mem_wmask[i]) w[((i+1)%9)*8+:8] = mem_wdata[((i+1)%9)*8+:8];
                end
                mem[mem_addr[31:3]] = w;
            end
        end
    end
endmodule

//--- test_dpg_guard.sv
// Self-checking bench for the partial write guard
`timescale 1ns/1ns
`include "dpg_consts.svh"
module test_dpg_guard;
    logic ref_clk, rstn, ecc_enable, byte_lane_enable_bit, partial_write_merge_enable, req_valid;
    logic req_ready, rsp_valid, rsp_error, err_corrected, err_uncorrectable, mem_valid, mem_write;
    logic mem_ready, mem_rvalid, slow, sc, su;
    logic [1:0] flip;
    logic [8:0] mem_wmask;
    logic [31:0] mem_addr, rx, a;
    logic [63:0] rsp_data, d;
    logic [69:0] e;
    logic [69:0] exp_q[$];
    dpg_pkg::dpg_range_t [`DPG_NUM_RANGES-1:0] prot_ranges;
    dpg_pkg::dpg_req_t req;
    dpg_pkg::dpg_word_t mem_wdata, mem_rdata;
    int mismatches, n_tests, cyc;

    dpg_guard u_dpg_guard (.ref_clk, .rstn, .ecc_enable, .byte_lane_enable_bit, .partial_write_merge_enable,
        .prot_ranges, .req_valid, .req, .req_ready, .rsp_valid, .rsp_data, .rsp_error, .err_corrected,
        .err_uncorrectable, .mem_valid, .mem_write, .mem_addr, .mem_wdata, .mem_wmask, .mem_ready,
        .mem_rvalid, .mem_rdata);
    dpg_mem_model u_dpg_mem_model (.ref_clk, .rstn, .slow, .flip, .mem_valid, .mem_write, .mem_addr,
        .mem_wdata, .mem_wmask, .mem_ready, .mem_rvalid, .mem_rdata);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] s, input logic [63:0] x);
        n_tests++;
        if (s !== x) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask

    function logic [63:0] rnd();
        rx ^= rx << 13;
        rx ^= rx >> 17;
        rx ^= rx << 5;
        return {rx, ~rx};
    endfunction

    // One outstanding request: note the expectation, hold until taken, wait for ready again
    task automatic xf(input logic [31:0] ad, input logic [63:0] wd, input logic [7:0] b, input logic w,
                      input logic [63:0] ed, input logic [5:0] f);
        int n;
        exp_q.push_back({ed, f});
        req = '{ad, wd, b, w};
        req_valid = 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        #1;
        req_valid = 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        #1;
    endtask

    // Error pulses are caught between edges so a trailing pulse is not lost
    always @(negedge ref_clk) begin
        if (err_corrected === 1'b1) sc = 1'b1;
        if (err_uncorrectable === 1'b1) su = 1'b1;
    end

    // Flags: data, error value, error checked, corrected, uncorrectable, flags checked
    initial begin
        forever begin
            @(posedge ref_clk);
            if (rsp_valid === 1'b1) begin
                e = exp_q.pop_front();
                if (e[5]) chk(rsp_data, e[69:6]);
                if (e[3]) chk({63'h0, rsp_error}, {63'h0, e[4]});
                @(posedge ref_clk);
                if (e[0]) chk({62'h0, sc, su}, {62'h0, e[2:1]});
                sc = 1'b0;
                su = 1'b0;
            end
        end
    end

    // The run needs a few hundred cycles; the ceiling catches a lost handshake
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            close_out();
        end
    end

    // Single-word requests never straddle a range edge
    initial begin
        rx = 32'h184f1;
        {rstn, ecc_enable, byte_lane_enable_bit, partial_write_merge_enable, req_valid, slow, sc, su} = 8'h0;
        flip = 2'h0;
        req = '0;
        prot_ranges = {32'h0000_8000, 32'h0000_80ff, 32'h0000_1000, 32'h0000_1fff};
        repeat (20) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        ecc_enable = 1'b1;
        byte_lane_enable_bit = 1'b1;
        d = rnd();
        xf(32'h4000, d, 8'hff, 1'b1, '0, 6'h09);
        flip = 2'h1;
        xf(32'h4000, '0, 8'hff, 1'b0, d ^ 64'h20, 6'h29);
        flip = 2'h0;
        xf(32'h1004, d, 8'hff, 1'b1, '0, 6'h19);
        xf(32'h1000, d, 8'h0f, 1'b1, '0, 6'h19);
        xf(32'h1002, '0, 8'hff, 1'b0, '0, 6'h19);
        // Both range edges; the second pass runs against a stalling memory
        for (int i = 0; i < 2; i++) begin
            a = i ? 32'h8000 : 32'h1ff8;
            slow = i[0];
            partial_write_merge_enable = 1'b1;
            d = rnd();
            xf(a, d, 8'h0f, 1'b1, '0, 6'h00);
            xf(a, d, 8'hf0, 1'b1, '0, 6'h09);
            xf(a + 32'h3, '0, 8'hff, 1'b0, d, 6'h29);
            flip = 2'h1;
            xf(a, '0, 8'hff, 1'b0, d, 6'h2d);
            flip = 2'h2;
            xf(a, '0, 8'hff, 1'b0, '0, 6'h03);
            flip = 2'h0;
            partial_write_merge_enable = 1'b0;
            xf(a, d, 8'h3c, 1'b1, '0, 6'h19);
        end
        // Fast memory so the check byte of the very first write cycle is what lands
        slow = 1'b0;
        xf(32'h1100, d, 8'hff, 1'b1, '0, 6'h09);
        xf(32'h1100, '0, 8'hff, 1'b0, d, 6'h29);
        byte_lane_enable_bit = 1'b0;
        d = rnd();
        xf(32'h1020, d, 8'h3c, 1'b1, '0, 6'h09);
        flip = 2'h1;
        xf(32'h1020, '0, 8'hff, 1'b0, (d & 64'h0000_ffff_ffff_0000) ^ 64'h20, 6'h29);
        // A note left in the queue means a response never came
        chk(64'(exp_q.size()), 64'h0);
        close_out();
    end
endmodule
